// File: pci_master_model.sv
// Purpose: External PCI bus master driving target reads and writes
// Assumes: FRAME and IRDY have pull-ups; cmd and wdata show inverse, addr the address, when released
// Notes: One xfer at a time; received words land in rx
`timescale 1ns/10ps
module pci_master_model (
  // Link
  input wire logic pci_clk,
  output logic pci_frame_n,
  output logic pci_irdy_n,
  output logic pci_cmd_write,
  output logic [pci_target_pkg::DATA_W-1:0] pci_addr,
  output logic [pci_target_pkg::DATA_W-1:0] pci_wdata,
  input wire logic pci_trdy_n,
  input wire logic pci_stop_n,
  input wire logic [pci_target_pkg::DATA_W-1:0] pci_rdata
);
  import pci_target_pkg::*;
  logic [DATA_W-1:0] rx [0:15];
  int got;
  logic stopped;
  logic hung;
  initial
  begin
    pci_frame_n = 1'b1;
    pci_irdy_n = 1'b1;
    pci_cmd_write = 1'b0;
    pci_addr = 32'h0;
    pci_wdata = 32'h0;
  end
  // ==========================================================
  // Transfer of n words, stall of wlen cycles after wat words
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
    input int n, input int wat, input int wlen);
    int w;
    got = 0;
    stopped = 1'b0;
    w = 0;
    repeat (2) @(posedge pci_clk);
    pci_frame_n <= 1'b0;
    pci_cmd_write <= wr;
    pci_addr <= a;
    @(posedge pci_clk);
    pci_frame_n <= (n == 1);
    pci_irdy_n <= 1'b0;
    pci_wdata <= d;
    pci_addr <= ~a;
    while (got < n && !stopped && w < 80)
    begin
      @(posedge pci_clk);
      w++;
      if (!pci_irdy_n && pci_trdy_n === 1'b0)
      begin
        rx[got] = pci_rdata;
        got++;
        w = 0;
        stopped = (pci_stop_n === 1'b0);
        if (got == n - 1)
          pci_frame_n <= 1'b1;
        if (got == wat && !stopped)
        begin
          pci_irdy_n <= 1'b1;
          repeat (wlen) @(posedge pci_clk);
          pci_irdy_n <= 1'b0;
        end
      end
      else if (pci_stop_n === 1'b0)
        stopped = 1'b1;
    end
    hung = (w >= 80);
    pci_frame_n <= 1'b1;
    pci_irdy_n <= 1'b1;
    pci_cmd_write <= ~wr;
    pci_addr <= a;
    pci_wdata <= ~d;
  endtask
endmodule // pci_master_model

// File: pci_target_fifo_control.sv
// Purpose: Target-side read prefetch and posted write FIFO control of a PCI bridge
// Assumes: FIFO depths are powers of two; config is changed only while the link is idle
// Notes: Link logic on pci_clk, FIFOs, registers and memory master on clock
`timescale 1ns/10ps
// Notes on behaviour
// - Leftover prefetched read data kept at transaction end unless discard bit set.
// - Prefetch streams until FIFO full, or fetches one burst when once bit set.
// - Read miss ends in Retry while memory keeps filling the read FIFO.
// - Target write completes once its data sits in the posted write FIFO.
// - Posted writes drain to memory only after any running read fill ends.
// - Repeated read finding its data in the FIFO returns it and completes.
// - No-timeout mode needs no-timeout, 16-word and 8-word bits all set.
// - Burst field matching 01XX or 1X1X selects sixteen doublewords.
// - In no-timeout mode a stalled transaction is never ended with STOP.
module pci_target_fifo_control #(
  parameter int RD_DEPTH = 16,
  parameter int WR_DEPTH = 16
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic [pci_target_pkg::REG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [pci_target_pkg::DATA_W-1:0] avs_writedata,
  output logic [pci_target_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Local memory
  output logic mem_req,
  output logic mem_we,
  output logic [pci_target_pkg::DATA_W-1:0] mem_addr,
  output logic [pci_target_pkg::DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [pci_target_pkg::DATA_W-1:0] mem_rdata,
  // PCI target link
  input wire logic pci_clk,
  input wire logic pci_rst,
  input wire logic pci_frame_n,
  input wire logic pci_irdy_n,
  input wire logic pci_cmd_write,
  input wire logic [pci_target_pkg::DATA_W-1:0] pci_addr,
  input wire logic [pci_target_pkg::DATA_W-1:0] pci_wdata,
  output logic pci_trdy_n,
  output logic pci_stop_n,
  output logic [pci_target_pkg::DATA_W-1:0] pci_rdata
);
  import pci_target_pkg::*;

  localparam int RAW = $clog2(RD_DEPTH);
  localparam int WAW = $clog2(WR_DEPTH);
  localparam int RCW = RAW + 1;
  localparam int WCW = WAW + 1;
  localparam logic [RCW-1:0] RD_FULL = RCW'(RD_DEPTH);
  localparam logic [WCW-1:0] WR_FULL = WCW'(WR_DEPTH);

  function automatic logic [4:0] burst_words(input logic [3:0] field);
    casez (field)
      4'b01??, 4'b1?1?: burst_words = BURST_WORDS_FULL;
      default: burst_words = BURST_WORDS_OTHER;
    endcase
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] upd, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      merge_bytes[i*8 +: 8] = be[i] ? upd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ==========================================================
  // Declarations
  logic [31:0] target_control_q, target_burst_length_q, rdata_q;
  logic wait_q, nt_mode_q;
  logic [4:0] burst_q;
  logic req_t_q, req_s1_q, req_s2_q, req_s3_q;
  logic end_t_q, end_s1_q, end_s2_q, end_s3_q;
  logic ack_t_q, ack_s1_q, ack_s2_q, ack_seen_q;
  logic [5:0] cfg_s1_q, cfg_s2_q;
  link_req_type link_req_q;
  link_reply_type reply_q;
  link_state_type p_state_q;
  logic [4:0] beat_q;
  logic [WAIT_W-1:0] wait_cnt_q;
  logic trdy_n_q, stop_n_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mem [RD_DEPTH];
  logic [RAW-1:0] rd_rp_q, rd_wp_q;
  logic [RCW-1:0] rd_cnt_q;
  logic [31:0] rd_head_q, fill_addr_q;
  logic fill_active_q;
  logic [4:0] fill_left_q;
  posted_write_type wr_mem [WR_DEPTH];
  logic [WAW-1:0] wr_rp_q, wr_wp_q;
  logic [WCW-1:0] wr_cnt_q;
  logic mem_req_q, mem_we_q;
  logic [31:0] mem_addr_q, mem_wdata_q;
  logic req_evt, end_evt, ack_evt, discard, once, hit, restart, flush, push, pop;
  logic fill_start, fill_done, drain_start, drain_done, wr_push, nt_s;
  logic [4:0] burst_s;
  logic [31:0] push_addr;

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign pci_trdy_n = trdy_n_q;
  assign pci_stop_n = stop_n_q;
  assign pci_rdata = prdata_q;

  // ==========================================================
  // Register slave, answers one cycle after the request
  always_ff @(posedge clock)
  begin
    if (rst)
      wait_q <= 1'b1;
    else
      wait_q <= !((avs_read || avs_write) && wait_q);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_q <= 32'h0;
    else if (avs_read && wait_q)
    begin
      case (avs_address)
        OFF_TARGET_CONTROL: rdata_q <= target_control_q;
        OFF_TARGET_BURST_LENGTH: rdata_q <= target_burst_length_q;
        OFF_STATUS:
        begin
          rdata_q <= 32'h0;
          rdata_q[STAT_RD_LSB +: RCW] <= rd_cnt_q;
          rdata_q[STAT_WR_LSB +: WCW] <= wr_cnt_q;
          rdata_q[STAT_FILL_BIT] <= fill_active_q;
          rdata_q[STAT_BUSY_BIT] <= mem_req_q;
        end
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      target_control_q <= TARGET_CONTROL_RESET;
      target_burst_length_q <= TARGET_BURST_LENGTH_RESET;
    end
    else if (avs_write && !wait_q)
    begin
      if (avs_address == OFF_TARGET_CONTROL)
        target_control_q <= merge_bytes(target_control_q, avs_writedata, avs_byteenable);
      if (avs_address == OFF_TARGET_BURST_LENGTH)
        target_burst_length_q <= merge_bytes(target_burst_length_q, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      nt_mode_q <= 1'b0;
      burst_q <= BURST_WORDS_OTHER;
    end
    else
    begin
      nt_mode_q <= target_control_q[BIT_NO_TIMEOUT] & target_control_q[BIT_READ_16WORD]
        & target_control_q[BIT_READ_8WORD];
      burst_q <= burst_words(target_burst_length_q[FIELD_BURST_LSB +: 4]);
    end
  end

  // ==========================================================
  // Crossings into the core domain
  always_ff @(posedge clock)
  begin
    if (rst)
      {req_s1_q, req_s2_q, req_s3_q, end_s1_q, end_s2_q, end_s3_q} <= 6'h0;
    else
    begin
      {req_s1_q, req_s2_q, req_s3_q} <= {req_t_q, req_s1_q, req_s2_q};
      {end_s1_q, end_s2_q, end_s3_q} <= {end_t_q, end_s1_q, end_s2_q};
    end
  end

  assign req_evt = req_s2_q ^ req_s3_q;
  assign end_evt = end_s2_q ^ end_s3_q;
  assign discard = target_control_q[BIT_DISCARD_LEFTOVER];
  assign once = target_control_q[BIT_PREFETCH_ONCE];
  assign push_addr = rd_head_q + 32'({rd_cnt_q, 2'b00});
  // head address follows the last read only
  assign hit = req_evt && !link_req_q.write && rd_cnt_q != '0 && rd_head_q == link_req_q.addr;
  assign restart = req_evt && !link_req_q.write && !hit
    && !(fill_active_q && rd_cnt_q == '0 && rd_head_q == link_req_q.addr);
  // leftover dropped on a restart, or at transaction end when discard set
  assign flush = restart || (end_evt && discard);
  assign pop = hit;
  assign push = mem_req_q && mem_ack && !mem_we_q && fill_active_q && !flush && mem_addr_q == push_addr;
  // stream until full or one burst
  assign fill_start = fill_active_q && !mem_req_q && !flush && rd_cnt_q < RD_FULL && (!once || fill_left_q != 5'h0);
  assign fill_done = fill_active_q && !mem_req_q && (rd_cnt_q == RD_FULL || (once && fill_left_q == 5'h0));
  // drain held off while a fill runs
  assign drain_start = !fill_active_q && !mem_req_q && !restart && wr_cnt_q != '0;
  assign drain_done = mem_req_q && mem_ack && mem_we_q;
  assign wr_push = req_evt && link_req_q.write && wr_cnt_q != WR_FULL;

  // ==========================================================
  // Read prefetch FIFO
  always_ff @(posedge clock)
  begin
    if (push)
      rd_mem[rd_wp_q] <= mem_rdata;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_rp_q <= '0;
      rd_wp_q <= '0;
      rd_cnt_q <= '0;
      rd_head_q <= 32'h0;
    end
    else
    begin
      if (flush)
      begin
        rd_rp_q <= rd_wp_q;
        rd_cnt_q <= '0;
      end
      else
      begin
        rd_rp_q <= rd_rp_q + RAW'(pop);
        rd_wp_q <= rd_wp_q + RAW'(push);
        rd_cnt_q <= rd_cnt_q + RCW'(push) - RCW'(pop);
      end
      if (restart)
        rd_head_q <= link_req_q.addr;
      else if (pop)
        rd_head_q <= rd_head_q + WORD_STEP;
    end
  end

  // miss starts or keeps a fill
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      fill_active_q <= 1'b0;
      fill_left_q <= 5'h0;
      fill_addr_q <= 32'h0;
    end
    else if (restart)
    begin
      fill_active_q <= 1'b1;
      fill_left_q <= burst_q;
      fill_addr_q <= link_req_q.addr;
    end
    else if (end_evt && discard)
      fill_active_q <= 1'b0;
    else if (fill_done)
      fill_active_q <= 1'b0;
    else if (fill_start)
    begin
      fill_left_q <= fill_left_q - 5'h1;
      fill_addr_q <= fill_addr_q + WORD_STEP;
    end
  end

  // ==========================================================
  // Posted write FIFO
  always_ff @(posedge clock)
  begin
    if (wr_push)
      wr_mem[wr_wp_q] <= '{addr: link_req_q.addr, data: link_req_q.data};
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_rp_q <= '0;
      wr_wp_q <= '0;
      wr_cnt_q <= '0;
    end
    else
    begin
      wr_wp_q <= wr_wp_q + WAW'(wr_push);
      wr_rp_q <= wr_rp_q + WAW'(drain_done);
      wr_cnt_q <= wr_cnt_q + WCW'(wr_push) - WCW'(drain_done);
    end
  end

  // ==========================================================
  // Local memory master, request held until acknowledged
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 32'h0;
      mem_wdata_q <= 32'h0;
    end
    else if (fill_start)
    begin
      mem_req_q <= 1'b1;
      mem_we_q <= 1'b0;
      mem_addr_q <= fill_addr_q;
    end
    else if (drain_start)
    begin
      mem_req_q <= 1'b1;
      mem_we_q <= 1'b1;
      mem_addr_q <= wr_mem[wr_rp_q].addr;
      mem_wdata_q <= wr_mem[wr_rp_q].data;
    end
    else if (mem_ack)
      mem_req_q <= 1'b0;
  end

  // Reply held stable until the next request
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reply_q <= '0;
      ack_t_q <= 1'b0;
    end
    else if (req_evt)
    begin
      reply_q.ok <= link_req_q.write ? wr_push : hit;
      reply_q.data <= rd_mem[rd_rp_q];
      ack_t_q <= ~ack_t_q;
    end
  end

  // ==========================================================
  // Link domain
  always_ff @(posedge pci_clk)
  begin
    if (pci_rst)
    begin
      {ack_s1_q, ack_s2_q, ack_seen_q} <= 3'h0;
      cfg_s1_q <= 6'h0;
      cfg_s2_q <= 6'h0;
    end
    else
    begin
      {ack_s1_q, ack_s2_q, ack_seen_q} <= {ack_t_q, ack_s1_q, ack_s2_q};
      cfg_s1_q <= {nt_mode_q, burst_q};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  assign ack_evt = ack_s2_q ^ ack_seen_q;
  assign nt_s = cfg_s2_q[5];
  assign burst_s = cfg_s2_q[4:0];

  always_ff @(posedge pci_clk)
  begin
    if (pci_rst)
    begin
      p_state_q <= P_IDLE;
      trdy_n_q <= 1'b1;
      stop_n_q <= 1'b1;
      prdata_q <= 32'h0;
      req_t_q <= 1'b0;
      end_t_q <= 1'b0;
      link_req_q <= '0;
      beat_q <= 5'h0;
      wait_cnt_q <= '0;
    end
    else
    begin
      wait_cnt_q <= '0;
      case (p_state_q)
        P_IDLE:
          if (!pci_frame_n)
          begin
            link_req_q.write <= pci_cmd_write;
            link_req_q.addr <= pci_addr;
            beat_q <= 5'h0;
            p_state_q <= P_ASK;
          end
        P_ASK:
          if (!link_req_q.write || !pci_irdy_n)
          begin
            link_req_q.data <= pci_wdata;
            req_t_q <= ~req_t_q;
            p_state_q <= P_WAIT;
          end
        P_WAIT:
          if (ack_evt)
          begin
            if (reply_q.ok)
            begin
              trdy_n_q <= 1'b0;
              prdata_q <= reply_q.data;
              stop_n_q <= !(beat_q + 5'h1 == burst_s && !nt_s);
              p_state_q <= P_DATA;
            end
            else
            begin
              stop_n_q <= 1'b0;
              p_state_q <= P_END;
            end
          end
        P_DATA:
          // data held while the master waits
          if (!pci_irdy_n)
          begin
            trdy_n_q <= 1'b1;
            beat_q <= beat_q + 5'h1;
            link_req_q.addr <= link_req_q.addr + WORD_STEP;
            p_state_q <= (pci_frame_n || !stop_n_q) ? P_END : P_ASK;
          end
          // timeout stop only outside no-timeout mode
          else if (!nt_s && wait_cnt_q == WAIT_LIMIT_CYCLES)
          begin
            trdy_n_q <= 1'b1;
            stop_n_q <= 1'b0;
            p_state_q <= P_END;
          end
          else
            wait_cnt_q <= wait_cnt_q + WAIT_W'(1);
        P_END:
          if (pci_frame_n && pci_irdy_n)
          begin
            stop_n_q <= 1'b1;
            if (!link_req_q.write && beat_q != 5'h0)
              end_t_q <= ~end_t_q;
            p_state_q <= P_IDLE;
          end
        default: p_state_q <= P_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence s_miss_answer;
    p_state_q == P_WAIT && ack_evt && !reply_q.ok;
  endsequence
  sequence s_hit_answer;
    p_state_q == P_WAIT && ack_evt && reply_q.ok;
  endsequence

  a_keep_leftover: assert property (@(posedge clock) disable iff (rst)
    end_evt && !discard && !req_evt |=> rd_cnt_q >= $past(rd_cnt_q)) else $error("leftover data lost");
  a_drop_leftover: assert property (@(posedge clock) disable iff (rst)
    end_evt && discard |=> rd_cnt_q == '0 && !fill_active_q) else $error("leftover data kept");
  a_fetch_once: assert property (@(posedge clock) disable iff (rst)
    fill_start && once |-> fill_left_q != 5'h0) else $error("fetch beyond one burst");
  a_miss_fills: assert property (@(posedge clock) disable iff (rst)
    req_evt && !link_req_q.write && !hit |=> fill_active_q && rd_head_q == $past(link_req_q.addr))
    else $error("miss did not fill");
  a_miss_retry: assert property (@(posedge pci_clk) disable iff (pci_rst)
    s_miss_answer |=> !stop_n_q && trdy_n_q && p_state_q == P_END) else $error("miss not retried");
  a_write_posted: assert property (@(posedge clock) disable iff (rst)
    req_evt && link_req_q.write && wr_cnt_q != WR_FULL |=> reply_q.ok ##0 $changed(ack_t_q))
    else $error("write not posted");
  a_drain_waits: assert property (@(posedge clock) disable iff (rst)
    $rose(mem_req_q) && mem_we_q |-> !$past(fill_active_q)) else $error("drain during fill");
  a_hit_returns: assert property (@(posedge pci_clk) disable iff (pci_rst)
    s_hit_answer |=> !trdy_n_q && prdata_q == $past(reply_q.data)) else $error("hit not returned");
  a_mode_decode: assert property (@(posedge clock) disable iff (rst)
    ##1 nt_mode_q == ($past(target_control_q[BIT_NO_TIMEOUT]) && $past(target_control_q[BIT_READ_16WORD])
    && $past(target_control_q[BIT_READ_8WORD])))
    else $error("no-timeout decode wrong");
  a_burst_decode: assert property (@(posedge clock) disable iff (rst)
    target_burst_length_q[7:6] == 2'b01 || (target_burst_length_q[7] && target_burst_length_q[5])
    |=> burst_q == BURST_WORDS_FULL) else $error("burst decode wrong");
  a_no_stop: assert property (@(posedge pci_clk) disable iff (pci_rst)
    nt_s && p_state_q == P_DATA && stop_n_q |=> stop_n_q) else $error("stop in no-timeout mode");
  a_next_addr: assert property (@(posedge clock) disable iff (rst)
    hit |=> rd_head_q == $past(link_req_q.addr) + WORD_STEP) else $error("read address slipped");
  a_last_word: assert property (@(posedge pci_clk) disable iff (pci_rst)
    nt_s && p_state_q == P_DATA && pci_irdy_n |=> !trdy_n_q && $stable(prdata_q)) else $error("last word dropped");
endmodule // pci_target_fifo_control

// File: pci_target_fifo_control_test.sv
// Purpose: Self-checking bench of the PCI target FIFO control
// Assumes: Local memory answers after four cycles
// Notes: Memory words hold a pattern of their address unless written
`timescale 1ns/10ps
module pci_target_fifo_control_test;
  import pci_target_pkg::*;
  logic clock = 1'b0, rst = 1'b1, pci_clk = 1'b0, pci_rst = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, mem_req, mem_we, mem_ack = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, mem_addr, mem_wdata, mem_rdata = 32'h0;
  logic pci_frame_n, pci_irdy_n, pci_cmd_write, pci_trdy_n, pci_stop_n;
  logic [31:0] pci_addr, pci_wdata, pci_rdata, s;
  logic [31:0] mem [logic [31:0]];
  int n_errors = 0, n_tests = 0, nrd = 0, wr_nrd = 0, mdly = 0, n0;
  always #20 clock = ~clock;
  initial #13 forever #40 pci_clk = ~pci_clk;
  pci_target_fifo_control pci_target_fifo_control_i (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .pci_clk(pci_clk), .pci_rst(pci_rst), .pci_frame_n(pci_frame_n),
    .pci_irdy_n(pci_irdy_n), .pci_cmd_write(pci_cmd_write), .pci_addr(pci_addr), .pci_wdata(pci_wdata),
    .pci_trdy_n(pci_trdy_n), .pci_stop_n(pci_stop_n), .pci_rdata(pci_rdata));
  pci_master_model pci_master_model_i (.pci_clk(pci_clk), .pci_frame_n(pci_frame_n),
    .pci_irdy_n(pci_irdy_n), .pci_cmd_write(pci_cmd_write), .pci_addr(pci_addr), .pci_wdata(pci_wdata),
    .pci_trdy_n(pci_trdy_n), .pci_stop_n(pci_stop_n), .pci_rdata(pci_rdata));
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
  endfunction
  // ==========================================================
  // Local memory
  always @(posedge clock)
  begin
    if (mem_req && !mem_ack && mdly == 3)
    begin
      mdly <= 0;
      mem_ack <= 1'b1;
      if (mem_we)
      begin
        mem[mem_addr] = mem_wdata;
        wr_nrd <= nrd;
      end
      else
      begin
        mem_rdata <= rd(mem_addr);
        nrd <= nrd + 1;
      end
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mdly <= (mem_req && !mem_ack) ? mdly + 1 : 0;
    end
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic reg_acc(input logic w, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_byteenable <= be;
    avs_writedata <= d;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    s = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    for (int i = 0; i < 400 && k < 2; i++)
    begin
      reg_acc(1'b0, OFF_STATUS, 4'hf, 32'h0);
      k = (s[17:16] == 2'b00 && s[12:8] == 5'h00) ? k + 1 : 0;
    end
    chk("idle", 32'h2, 32'(k));
  endtask
  task automatic rd1(input logic [31:0] a, input logic miss);
    pci_master_model_i.xfer(1'b0, a, 32'h0, 1, 99, 0);
    chk("retry", 32'(miss), 32'(pci_master_model_i.stopped && pci_master_model_i.got == 0));
    if (!miss)
      chk("rdata", rd(a), pci_master_model_i.rx[0]);
  endtask
  task automatic burst(input logic [31:0] a, input int wat, input int wlen, input int egot, input logic estop);
    rd1(a, 1'b1);
    wait_idle();
    pci_master_model_i.xfer(1'b0, a, 32'h0, 16, wat, wlen);
    if (egot >= 0)
      chk("words", 32'(egot), 32'(pci_master_model_i.got));
    chk("stop", 32'(estop), 32'(pci_master_model_i.stopped));
    chk("hang", 32'h0, 32'(pci_master_model_i.hung));
    for (int i = 0; i < pci_master_model_i.got; i++)
      chk("bdata", rd(a + 32'(4 * i)), pci_master_model_i.rx[i]);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [3:0] ad [4] = '{4'h0, 4'h4, 4'h8, 4'hc};
    foreach (ad[i])
    begin
      reg_acc(1'b0, ad[i], 4'hf, 32'h0);
      chk("reset", 32'h0, s);
    end
    reg_acc(1'b1, OFF_STATUS, 4'hf, 32'hffff_ffff);
    reg_acc(1'b1, 4'hc, 4'hf, 32'hffff_ffff);
    reg_acc(1'b0, OFF_STATUS, 4'hf, 32'h0);
    chk("status", 32'h0, s);
    reg_acc(1'b0, 4'hc, 4'hf, 32'h0);
    chk("unmapped", 32'h0, s);
    reg_acc(1'b1, OFF_TARGET_BURST_LENGTH, 4'h5, 32'h1234_5678);
    reg_acc(1'b0, OFF_TARGET_BURST_LENGTH, 4'hf, 32'h0);
    chk("lanes", 32'h0034_0078, s);
    reg_acc(1'b1, OFF_TARGET_BURST_LENGTH, 4'hf, 32'h0);
  endtask
  task automatic t_retry_post();
    n0 = nrd;
    rd1(32'h1000, 1'b1);
    pci_master_model_i.xfer(1'b1, 32'h8000, 32'hcafe_0001, 1, 99, 0);
    chk("wr_done", 32'h1, 32'(pci_master_model_i.got));
    wait_idle();
    chk("fill_first", 32'd16, 32'(wr_nrd - n0));
    chk("posted", 32'hcafe_0001, mem[32'h8000]);
    rd1(32'h1000, 1'b0);
    rd1(32'h1004, 1'b0);
  endtask
  task automatic t_discard();
    reg_acc(1'b1, OFF_TARGET_CONTROL, 4'hf, 32'h0008_0000);
    burst(32'h2000, 99, 0, 8, 1'b1);
    rd1(32'h2020, 1'b1);
    wait_idle();
    reg_acc(1'b1, OFF_TARGET_CONTROL, 4'hf, 32'h0);
  endtask
  task automatic t_once();
    reg_acc(1'b1, OFF_TARGET_CONTROL, 4'hf, 32'h0000_1000);
    n0 = nrd;
    rd1(32'h3000, 1'b1);
    wait_idle();
    chk("once", 32'd8, 32'(nrd - n0));
    reg_acc(1'b1, OFF_TARGET_CONTROL, 4'hf, 32'h0);
    wait_idle();
  endtask
  task automatic t_bursts();
    logic [3:0] f [4] = '{4'h4, 4'ha, 4'h7, 4'hf};
    burst(32'h4000, 99, 0, 8, 1'b1);
    reg_acc(1'b1, OFF_TARGET_CONTROL, 4'hf, 32'h0004_0028);
    foreach (f[i])
    begin
      reg_acc(1'b1, OFF_TARGET_BURST_LENGTH, 4'hf, {24'h0, f[i], 4'h0});
      burst(32'h5000 + 32'(i * 256), 15, 40, 16, 1'b0);
    end
    wait_idle();
    reg_acc(1'b1, OFF_TARGET_CONTROL, 4'hf, 32'h0004_0020);
    burst(32'h6000, 4, 40, 4, 1'b1);
  endtask
  // ==========================================================
  // Run control
  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    pci_rst <= 1'b0;
    repeat (4) @(posedge pci_clk);
    t_regs();
    t_retry_post();
    t_discard();
    t_once();
    t_bursts();
    finish_test();
  end
endmodule // pci_target_fifo_control_test

// File: pci_target_pkg.sv
// Purpose: Shared constants and carriers for the PCI target FIFO control block
// Assumes: 32-bit local bus, byte-addressed Avalon-MM register window
// Notes: Register offsets are byte addresses on the register bus
package pci_target_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W = 32;
  localparam int REG_ADDR_W = 4;
  localparam int WAIT_W = 8;
  // ==========================================================
  // Register map
  localparam logic [3:0] OFF_TARGET_CONTROL = 4'h0;
  localparam logic [3:0] OFF_TARGET_BURST_LENGTH = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [31:0] TARGET_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] TARGET_BURST_LENGTH_RESET = 32'h0000_0000;
  // ==========================================================
  // Field positions
  localparam int BIT_DISCARD_LEFTOVER = 19;
  localparam int BIT_NO_TIMEOUT = 18;
  localparam int BIT_PREFETCH_ONCE = 12;
  localparam int BIT_READ_16WORD = 5;
  localparam int BIT_READ_8WORD = 3;
  localparam int FIELD_BURST_LSB = 4;
  localparam int STAT_RD_LSB = 0;
  localparam int STAT_WR_LSB = 8;
  localparam int STAT_FILL_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;
  // ==========================================================
  // Burst sizes and timing counts
  localparam logic [4:0] BURST_WORDS_FULL = 5'h10;
  localparam logic [4:0] BURST_WORDS_OTHER = 5'h08;
  localparam logic [WAIT_W-1:0] WAIT_LIMIT_CYCLES = 8'h10;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic write;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } link_req_type;
  typedef struct packed {
    logic ok;
    logic [DATA_W-1:0] data;
  } link_reply_type;
  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } posted_write_type;
  typedef enum logic [4:0] {
    P_IDLE = 5'b00001,
    P_ASK = 5'b00010,
    P_WAIT = 5'b00100,
    P_DATA = 5'b01000,
    P_END = 5'b10000
  } link_state_type;
endpackage
